// ---- rtl/ddc_defs.vh ----
// register offsets, field positions, reset values and timing counts for the dual dac control
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH
`define DDC_ADR_CTRL 6'h00
`define DDC_ADR_SWTRIG 6'h04
`define DDC_ADR_R12_1 6'h08
`define DDC_ADR_L12_1 6'h0c
`define DDC_ADR_R8_1 6'h10
`define DDC_ADR_R12_2 6'h14
`define DDC_ADR_L12_2 6'h18
`define DDC_ADR_R8_2 6'h1c
`define DDC_ADR_R12_D 6'h20
`define DDC_ADR_L12_D 6'h24
`define DDC_ADR_R8_D 6'h28
`define DDC_ADR_OUT1 6'h2c
`define DDC_ADR_OUT2 6'h30
`define DDC_ADR_FIFO 6'h34
`define DDC_ADR_STAT 6'h38
`define DDC_CTRL_MASK 32'h1fff1fff
`define DDC_CH2_SHIFT 16
`define DDC_TEN_BIT 2
`define DDC_TSEL_LSB 3
`define DDC_WAVE_LSB 6
`define DDC_MAMP_LSB 8
`define DDC_TSEL_SW 3'h7
`define DDC_WAVE_NOISE 2'h1
`define DDC_NOISE_SEED 12'haaa
`define DDC_TRIG_DELAY 2'h3
`endif

// ---- rtl/ddc_fifo.v ----
// parameterised sample fifo with valid and ready on both sides
`timescale 1ns/10ps
module ddc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign level_o = count;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // storage has no reset, only pointers and count need a defined state
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/ddc_wave.v ----
// per-channel trigger delay, noise register, triangle counter and output register
`timescale 1ns/10ps
`include "ddc_defs.vh"
module ddc_wave (
  input wire clk_i,
  input wire rst_i,
  input wire trig_en_i,
  input wire [1:0] wave_sel_i,
  input wire [3:0] amp_sel_i,
  input wire [11:0] held_i,
  input wire held_wr_i,
  input wire trig_i,
  input wire trig_sw_i,
  output reg [11:0] out_value_o,
  output wire busy_o,
  output reg done_o
);
  reg [1:0] dly;
  reg [11:0] noise;
  reg [11:0] tri_cnt;
  reg tri_down;
  wire direct;
  wire [11:0] mask;
  wire [11:0] addend;
  wire [12:0] sum;
  wire fire;
  wire fb;

  // unmask bits [amp:0], amplitude 2^(amp+1)-1, saturating at 12 bits
  assign mask = (amp_sel_i >= 4'hb) ? 12'hfff : ((12'h002 << amp_sel_i) - 12'h001);
  assign addend = (wave_sel_i == `DDC_WAVE_NOISE) ? (noise & mask) :
                  (wave_sel_i[1] ? tri_cnt : 12'h000);
  assign sum = {1'b0, held_i} + {1'b0, addend};
  assign fire = (dly == 2'h1);
  assign busy_o = (dly != 2'h0);
  assign fb = noise[0] ^ noise[1] ^ noise[4] ^ noise[6];
  // trigger off: a freshly held value goes out at the very next edge
  assign direct = held_wr_i & ~trig_en_i;

  // a line trigger starts the countdown; the load lands three cycles after its edge, two after a software bit is set
  always @(posedge clk_i) begin
    if (rst_i) begin
      dly <= 2'h0;
    end else begin
      // done_o blocks a software bit still set from retriggering; an edge then is lost
      if (trig_en_i & trig_i & (dly == 2'h0) & ~done_o) begin
        // the line sampler already used one of the three cycles
        dly <= trig_sw_i ? 2'h1 : (`DDC_TRIG_DELAY - 2'h1);
      end else if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end
    end
  end

  // output register; wave terms only count while triggers are enabled
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_value_o <= 12'h000;
      done_o <= 1'b0;
    end else begin
      done_o <= fire & trig_en_i;
      if (direct) begin
        out_value_o <= held_i;
      end else if (fire & trig_en_i) begin
        out_value_o <= sum[12] ? 12'hfff : sum[11:0];
      end
    end
  end

  // noise and triangle state advance after the load that used them
  always @(posedge clk_i) begin
    if (rst_i || wave_sel_i == 2'h0) begin
      noise <= `DDC_NOISE_SEED;
      tri_cnt <= 12'h000;
      tri_down <= 1'b0;
    end else if (fire & trig_en_i) begin
      if (wave_sel_i == `DDC_WAVE_NOISE) begin
        // anti lock-up: an all-zero register gets a one injected
        noise <= (noise == 12'h000) ? 12'h001 : {fb, noise[11:1]};
      end else begin
        if (~tri_down && tri_cnt < mask) begin
          tri_cnt <= tri_cnt + 12'h001;
        end else if (tri_cnt != 12'h000) begin
          tri_down <= 1'b1;
          tri_cnt <= tri_cnt - 12'h001;
        end else begin
          tri_down <= 1'b0;
          tri_cnt <= 12'h001;
        end
      end
    end
  end
endmodule

// ---- rtl/ddc_top.v ----
// dual dac channel update control with wishbone register slave and sample fifo
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "ddc_defs.vh"
module ddc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  input wire [5:0] timer_trig_i,
  input wire ext_line_i,
  output wire [11:0] ch1_output_value_o,
  output wire [11:0] ch2_output_value_o,
  output wire ch1_enable_o,
  output wire ch2_enable_o,
  output wire ch1_buffer_off_o,
  output wire ch2_buffer_off_o,
  output wire ch1_dma_enable_o,
  output wire ch2_dma_enable_o
);
  reg [31:0] ctrl;
  reg [1:0] sw_trig;
  reg [11:0] ch1_held_sample;
  reg [11:0] ch2_held_sample;
  reg [6:0] trig_q;
  reg [6:0] trig_prev;
  reg [1:0] held_wr;
  reg fifo_pop_q;
  wire req;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] wdata;
  wire f_in_ready;
  wire f_out_valid;
  wire [31:0] f_out_data;
  wire [FIFO_AW:0] f_level;
  wire f_push;
  wire f_pop;
  wire [1:0] f_held_wr;
  wire [1:0] trig_hit;
  wire [1:0] trig_sw;
  wire [1:0] busy;
  wire [1:0] done;
  wire [2:0] tsel1;
  wire [2:0] tsel2;

  // byte lanes expand to a bit mask for partial writes
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata = dat_i & wmask;
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr = req & we_i;
  assign tsel1 = ctrl[`DDC_TSEL_LSB+2:`DDC_TSEL_LSB];
  assign tsel2 = ctrl[`DDC_CH2_SHIFT+`DDC_TSEL_LSB+2:`DDC_CH2_SHIFT+`DDC_TSEL_LSB];
  assign ch1_enable_o = ctrl[0];
  assign ch2_enable_o = ctrl[16];
  assign ch1_buffer_off_o = ctrl[1];
  assign ch2_buffer_off_o = ctrl[17];
  assign ch1_dma_enable_o = ctrl[12];
  assign ch2_dma_enable_o = ctrl[28];

  // fifo word pairs both channels like the right-aligned 12-bit combined register
  assign f_push = wr && adr_i == `DDC_ADR_FIFO && f_in_ready;
  assign f_pop = f_out_valid & ~fifo_pop_q & ~busy[0] & ~busy[1]
                 & ~held_wr[0] & ~held_wr[1];
  assign f_held_wr = {2{f_pop}};

  // pick the selected source; software source comes from the software trigger bits
  function trig_pick;
    input [2:0] tsel;
    input [6:0] edges;
    input sw;
    begin
      if (tsel == `DDC_TSEL_SW) begin
        trig_pick = sw;
      end else begin
        trig_pick = edges[tsel];
      end
    end
  endfunction

  // registered sampling of trigger lines, rising edge detected afterwards
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 7'h00;
      trig_prev <= 7'h00;
    end else begin
      trig_q <= {ext_line_i, timer_trig_i};
      trig_prev <= trig_q;
    end
  end

  assign trig_hit[0] = trig_pick(tsel1, trig_q & ~trig_prev, sw_trig[0]);
  assign trig_hit[1] = trig_pick(tsel2, trig_q & ~trig_prev, sw_trig[1]);
  assign trig_sw[0] = (tsel1 == `DDC_TSEL_SW);
  assign trig_sw[1] = (tsel2 == `DDC_TSEL_SW);

  // register writes, held samples and software trigger self-clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 32'h00000000;
      sw_trig <= 2'h0;
      ch1_held_sample <= 12'h000;
      ch2_held_sample <= 12'h000;
      held_wr <= 2'h0;
      fifo_pop_q <= 1'b0;
    end else begin
      held_wr <= f_held_wr;
      fifo_pop_q <= f_pop;
      if (f_pop) begin
        ch1_held_sample <= f_out_data[11:0];
        ch2_held_sample <= f_out_data[27:16];
      end
      // hardware clear loses to a software set in the same cycle
      if (done[0]) begin
        sw_trig[0] <= 1'b0;
      end
      if (done[1]) begin
        sw_trig[1] <= 1'b0;
      end
      if (wr) begin
        case (adr_i)
          `DDC_ADR_CTRL: begin
            ctrl <= (ctrl & ~wmask) | (wdata & `DDC_CTRL_MASK);
          end
          `DDC_ADR_SWTRIG: begin
            if (wdata[0]) begin
              sw_trig[0] <= 1'b1;
            end
            if (wdata[1]) begin
              sw_trig[1] <= 1'b1;
            end
          end
          `DDC_ADR_R12_1: begin
            ch1_held_sample <= wdata[11:0];
            held_wr <= 2'h1;
          end
          `DDC_ADR_L12_1: begin
            ch1_held_sample <= wdata[15:4];
            held_wr <= 2'h1;
          end
          `DDC_ADR_R8_1: begin
            ch1_held_sample <= {wdata[7:0], 4'h0};
            held_wr <= 2'h1;
          end
          `DDC_ADR_R12_2: begin
            ch2_held_sample <= wdata[11:0];
            held_wr <= 2'h2;
          end
          `DDC_ADR_L12_2: begin
            ch2_held_sample <= wdata[15:4];
            held_wr <= 2'h2;
          end
          `DDC_ADR_R8_2: begin
            ch2_held_sample <= {wdata[7:0], 4'h0};
            held_wr <= 2'h2;
          end
          `DDC_ADR_R12_D: begin
            ch1_held_sample <= wdata[11:0];
            ch2_held_sample <= wdata[27:16];
            held_wr <= 2'h3;
          end
          `DDC_ADR_L12_D: begin
            ch1_held_sample <= wdata[15:4];
            ch2_held_sample <= wdata[31:20];
            held_wr <= 2'h3;
          end
          `DDC_ADR_R8_D: begin
            ch1_held_sample <= {wdata[7:0], 4'h0};
            ch2_held_sample <= {wdata[15:8], 4'h0};
            held_wr <= 2'h3;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // single-cycle wishbone answer; unmapped offsets answer with err
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
      if (req) begin
        if (adr_i > `DDC_ADR_STAT || adr_i[1:0] != 2'h0) begin
          err_o <= 1'b1;
        end else begin
          ack_o <= 1'b1;
        end
        case (adr_i)
          `DDC_ADR_CTRL: dat_o <= ctrl;
          `DDC_ADR_SWTRIG: dat_o <= {30'h0, sw_trig};
          `DDC_ADR_R12_1: dat_o <= {20'h0, ch1_held_sample};
          `DDC_ADR_R12_2: dat_o <= {20'h0, ch2_held_sample};
          `DDC_ADR_R12_D: dat_o <= {4'h0, ch2_held_sample, 4'h0, ch1_held_sample};
          `DDC_ADR_OUT1: dat_o <= {20'h0, ch1_output_value_o};
          `DDC_ADR_OUT2: dat_o <= {20'h0, ch2_output_value_o};
          `DDC_ADR_STAT: dat_o <= {24'h0, busy, f_in_ready, f_level};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  ddc_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(f_push),
    .in_ready_o(f_in_ready),
    .in_data_i(wdata),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_out_data),
    .level_o(f_level)
  );

  // two independent channels; a shared source simply triggers both at once
  ddc_wave u_ch1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_en_i(ctrl[`DDC_TEN_BIT]),
    .wave_sel_i(ctrl[`DDC_WAVE_LSB+1:`DDC_WAVE_LSB]),
    .amp_sel_i(ctrl[`DDC_MAMP_LSB+3:`DDC_MAMP_LSB]),
    .held_i(ch1_held_sample),
    .held_wr_i(held_wr[0]),
    .trig_i(trig_hit[0]),
    .trig_sw_i(trig_sw[0]),
    .out_value_o(ch1_output_value_o),
    .busy_o(busy[0]),
    .done_o(done[0])
  );

  ddc_wave u_ch2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_en_i(ctrl[`DDC_CH2_SHIFT+`DDC_TEN_BIT]),
    .wave_sel_i(ctrl[`DDC_CH2_SHIFT+`DDC_WAVE_LSB+1:`DDC_CH2_SHIFT+`DDC_WAVE_LSB]),
    .amp_sel_i(ctrl[`DDC_CH2_SHIFT+`DDC_MAMP_LSB+3:`DDC_CH2_SHIFT+`DDC_MAMP_LSB]),
    .held_i(ch2_held_sample),
    .held_wr_i(held_wr[1]),
    .trig_i(trig_hit[1]),
    .trig_sw_i(trig_sw[1]),
    .out_value_o(ch2_output_value_o),
    .busy_o(busy[1]),
    .done_o(done[1])
  );
endmodule

// ---- test/ddc_checker_assertions.sv ----
// port checker for the dual dac control, bound to the top module
`timescale 1ns/10ps
module ddc_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire [5:0] timer_trig_i,
  input wire ext_line_i,
  input wire [11:0] ch1_output_value_o,
  input wire [11:0] ch2_output_value_o
);
  reg [31:0] ctl;
  reg [11:0] h1;
  reg [11:0] h2;
  wire tk = cyc_i && stb_i && !ack_o && !err_o;
  wire wr = tk && we_i;
  wire [7:0] src = {1'b0, ext_line_i, timer_trig_i};
  // shadow of control and right-aligned held values; assumes full-word writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= 32'h0;
      h1 <= 12'h0;
      h2 <= 12'h0;
    end else if (wr) begin
      if (adr_i == 6'h00) ctl <= dat_i;
      if (adr_i == 6'h20 || adr_i == 6'h08) h1 <= dat_i[11:0];
      if (adr_i == 6'h20) h2 <= dat_i[27:16];
      if (adr_i == 6'h14) h2 <= dat_i[11:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_answer; tk |=> (ack_o != err_o); endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_err; tk && (adr_i[1:0] != 2'h0 || adr_i > 6'h38) |=> err_o; endproperty
  a_err: assert property (p_err) else $error("bad address not refused");
  property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_direct2;
    wr && adr_i == 6'h20 && !ctl[2] && !ctl[18] |->
      ##[1:2] (ch1_output_value_o == h1 && ch2_output_value_o == h2);
  endproperty
  a_direct2: assert property (p_direct2) else $error("dual direct load late");
  property p_direct1; wr && adr_i == 6'h08 && !ctl[2] |-> ##[1:2] ch1_output_value_o == h1;
  endproperty
  a_direct1: assert property (p_direct1) else $error("direct load late");
  property p_trig1;
    ctl[2] && ctl[7:6] == 2'h0 && ctl[5:3] != ctl[21:19] && $rose(src[ctl[5:3]]) |->
      ##1 ($stable(ch1_output_value_o) && $stable(ch2_output_value_o)) [*3]
      ##1 (ch1_output_value_o == h1 && $stable(ch2_output_value_o));
  endproperty
  a_trig1: assert property (p_trig1) else $error("single trigger load wrong");
  property p_trig2;
    ctl[2] && ctl[18] && ctl[5:3] == ctl[21:19] && ctl[7:6] == 2'h0 &&
      ctl[23:22] == 2'h0 && $rose(src[ctl[5:3]]) |->
      ##4 (ch1_output_value_o == h1 && ch2_output_value_o == h2);
  endproperty
  a_trig2: assert property (p_trig2) else $error("shared trigger load wrong");
  property p_rst;
    disable iff (1'b0) rst_i |=> ch1_output_value_o == 12'h0 && ch2_output_value_o == 12'h0
      && !ack_o && !err_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind ddc_top ddc_checker i_ddc_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .timer_trig_i(timer_trig_i), .ext_line_i(ext_line_i),
  .ch1_output_value_o(ch1_output_value_o), .ch2_output_value_o(ch2_output_value_o));

// ---- test/ddc_trig_src.sv ----
// trigger timers and external line as seen from the block's far side
`timescale 1ns/10ps
module ddc_trig_src (
  input wire clk_i,
  output reg [5:0] timer_trig_o,
  output reg ext_line_o
);
  initial begin
    timer_trig_o = 6'h00;
    ext_line_o = 1'b0;
  end
  // one rising edge per event; lines idle low so no stray edge appears
  task pulse(input [6:0] m);
    begin
      @(posedge clk_i);
      {ext_line_o, timer_trig_o} <= m;
      @(posedge clk_i);
      {ext_line_o, timer_trig_o} <= 7'h00;
    end
  endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the dual dac control
`timescale 1ns/10ps
module tb;
  reg clk_i;
  reg rst_i;
  reg cyc;
  reg stb;
  reg we;
  reg [5:0] adr;
  reg [31:0] dat;
  reg [31:0] rd;
  reg e;
  integer errors;
  integer checks_done;
  wire [31:0] dat_o;
  wire ack_o;
  wire err_o;
  wire [5:0] tt;
  wire xl;
  wire [11:0] ch1;
  wire [11:0] ch2;
  wire [5:0] flags;
  ddc_top i_ddc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .timer_trig_i(tt), .ext_line_i(xl), .ch1_output_value_o(ch1), .ch2_output_value_o(ch2),
    .ch1_enable_o(flags[0]), .ch2_enable_o(flags[3]), .ch1_buffer_off_o(flags[1]),
    .ch2_buffer_off_o(flags[4]), .ch1_dma_enable_o(flags[2]), .ch2_dma_enable_o(flags[5]));
  ddc_trig_src i_ddc_trig_src (.clk_i(clk_i), .timer_trig_o(tt), .ext_line_o(xl));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // classic cycle: hold the request until ack or err is sampled high
  task wb(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
      rd = dat_o;
      e = err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) errors = errors + 1;
    end
  endtask
  task rdchk(input [5:0] a, input [31:0] x);
    begin
      wb(1'b0, a, 32'h0);
      chk(rd, x);
    end
  endtask
  // write a holding register and compare both outputs once settled
  task ld(input [5:0] a, input [31:0] d, input [11:0] e1, e2);
    begin
      wb(1'b1, a, d);
      repeat (2) @(posedge clk_i);
      #1;
      chk(ch1, e1);
      chk(ch2, e2);
    end
  endtask
  // outputs must hold until the third cycle after the sampled edge
  task trig(input [6:0] m, input [11:0] o1, o2, n1, n2);
    begin
      i_ddc_trig_src.pulse(m);
      repeat (2) @(posedge clk_i);
      #1;
      chk(ch1, o1);
      chk(ch2, o2);
      @(posedge clk_i);
      #1;
      chk(ch1, n1);
      chk(ch2, n2);
    end
  endtask
  initial begin
    #(25 * 5000);
    errors = errors + 1;
    test_done;
  end
  initial begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    dat = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(6'h2c, 32'h0);
    rdchk(6'h30, 32'h0);
    wb(1'b1, 6'h00, 32'hffffffff);
    rdchk(6'h00, 32'h1fff1fff);
    chk(flags, 6'h3f);
    wb(1'b1, 6'h3c, 32'h1);
    chk(e, 1'b1);
    wb(1'b0, 6'h02, 32'h0);
    chk(e, 1'b1);
    wb(1'b1, 6'h00, 32'h0);
    ld(6'h20, 32'h0abc0123, 12'h123, 12'habc);
    ld(6'h24, 32'hfed04560, 12'h456, 12'hfed);
    ld(6'h28, 32'h0000c35a, 12'h5a0, 12'hc30);
    rdchk(6'h2c, 32'h5a0);
    ld(6'h14, 32'h00000321, 12'h5a0, 12'h321);
    ld(6'h08, 32'h00000234, 12'h234, 12'h321);
    ld(6'h0c, 32'h00007770, 12'h777, 12'h321);
    ld(6'h1c, 32'h00000099, 12'h777, 12'h990);
    // independent sources: timer 0 for one, timer 1 for two
    wb(1'b1, 6'h00, 32'h000c0004);
    ld(6'h20, 32'h02220111, 12'h777, 12'h990);
    trig(7'h01, 12'h777, 12'h990, 12'h111, 12'h990);
    trig(7'h02, 12'h111, 12'h990, 12'h111, 12'h222);
    // shared external line
    wb(1'b1, 6'h00, 32'h00340034);
    ld(6'h20, 32'h04440333, 12'h111, 12'h222);
    trig(7'h40, 12'h111, 12'h222, 12'h333, 12'h444);
    // shared noise, masks of four and twelve bits, seed still unused
    wb(1'b1, 6'h00, 32'h0b6c036c);
    ld(6'h20, 32'h07000100, 12'h333, 12'h444);
    trig(7'h20, 12'h333, 12'h444, 12'h10a, 12'hfff);
    // shared triangle, amplitudes one and three
    wb(1'b1, 6'h00, 32'h01a400a4);
    ld(6'h20, 32'h08000200, 12'h10a, 12'hfff);
    trig(7'h10, 12'h10a, 12'hfff, 12'h200, 12'h800);
    trig(7'h10, 12'h200, 12'h800, 12'h201, 12'h801);
    trig(7'h10, 12'h201, 12'h801, 12'h200, 12'h802);
    // software source on both channels: load two cycles after the bit is set
    wb(1'b1, 6'h00, 32'h003c003c);
    ld(6'h20, 32'h06660555, 12'h200, 12'h802);
    wb(1'b1, 6'h04, 32'h00000003);
    @(posedge clk_i);
    #1;
    chk(ch1, 12'h555);
    chk(ch2, 12'h666);
    rdchk(6'h04, 32'h0);
    // fifo word reaches both outputs; pops at once, so it never fills here
    wb(1'b1, 6'h00, 32'h0);
    wb(1'b1, 6'h34, 32'h0aaa0555);
    repeat (4) @(posedge clk_i);
    #1;
    chk(ch1, 12'h555);
    chk(ch2, 12'haaa);
    rdchk(6'h38, 32'h20);
    test_done;
  end
endmodule
